// >>> shared/mcju_pkg.sv
// Purpose: Constants, opcode patterns and types of the conditional jump unit
// Assumes: 16-bit instruction words, 10-bit code RAM addresses
// Notes:   Register offsets are word addresses on the plain register port
`default_nettype none

package mcju_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W     = 10;
  localparam int INS_W    = 16;
  localparam int OFS_W    = 5;
  localparam int SR_W     = 16;
  localparam int ST_N     = 8;
  localparam int RA_W     = 9;
  localparam int RD_W     = 16;
  localparam int ST_SEL_W = 5;
  localparam int SR_SEL_W = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OPC_MSB     = 15;
  localparam int SEL_LSB     = 5;
  localparam int POL_BIT     = 9;
  localparam int JR_BIT      = 4;
  localparam int FC_SEL_BIT  = 4;
  localparam int FC_JR_BIT   = 3;
  localparam int RC_SEL_BIT  = 5;
  localparam int GRP_HI_BIT  = 4;
  localparam int LAST_TK_BIT = 15;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [10:0] FC_HI = 11'h1CC;
  localparam logic [2:0]  FC_LO = 3'h5;
  localparam logic [9:0]  RC_HI = 10'h0BD;
  localparam logic [5:0]  FS_HI = 6'h0E;
  localparam logic [3:0]  FS_LO = 4'h4;
  localparam logic [5:0]  RS_HI = 6'h05;
  localparam logic [5:0]  FR_HI = 6'h0F;
  localparam logic [3:0]  FR_LO = 4'h5;
  localparam logic [5:0]  RR_HI = 6'h0C;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [RA_W-1:0] REG_C0_A = 9'h105;
  localparam logic [RA_W-1:0] REG_C1_A = 9'h106;
  localparam logic [RA_W-1:0] REG_C0_B = 9'h125;
  localparam logic [RA_W-1:0] REG_C1_B = 9'h126;
  localparam logic [RA_W-1:0] REG_C0_C = 9'h145;
  localparam logic [RA_W-1:0] REG_C1_C = 9'h146;
  localparam logic [RA_W-1:0] REG_LAST = 9'h160;
  localparam logic [SR_W-1:0] SR_RST   = 16'h0000;

  // ----------------------------------------------------------------
  // Start selector codes
  // ----------------------------------------------------------------
  localparam logic [ST_SEL_W-1:0] START_NONE = 5'h00;
  localparam logic [ST_SEL_W-1:0] START_MAX  = 5'h1B;

  typedef enum logic [2:0] {
    K_NONE, K_FAR_CORE, K_REL_CORE, K_FAR_START,
    K_REL_START, K_FAR_STAT, K_REL_STAT
  } mcju_kind_e;

  // Mask of starts named by a selector, bit 0 is start 1
  function automatic logic [ST_N-1:0] start_mask(input logic [ST_SEL_W-1:0] sel);
    logic [ST_N-1:0] m;
    m = 8'h00;
    if (!sel[GRP_HI_BIT]) begin
      m = {4'h0, sel[SR_SEL_W-1:0]};
    end else begin
      unique case (sel[SR_SEL_W-1:0])
        4'h0:    m = 8'h10;
        4'h1:    m = 8'h40;
        4'h2:    m = 8'h50;
        4'h3:    m = 8'h60;
        4'h4:    m = 8'h80;
        4'h5:    m = 8'h90;
        4'h6:    m = 8'hA0;
        4'h7:    m = 8'hB0;
        4'h8:    m = 8'hC0;
        4'h9:    m = 8'hD0;
        4'hA:    m = 8'hE0;
        4'hB:    m = 8'hF0;
        default: m = 8'h00;
      endcase
    end
    return m;
  endfunction : start_mask

endpackage : mcju_pkg

`default_nettype wire

// >>> shared/mcju_dec_if.sv
// Purpose: Carries an instruction word to the decoder and its fields back
// Assumes: Purely combinational between the two ends
// Notes:   None
`default_nettype none

interface mcju_dec_if;
  logic [mcju_pkg::INS_W-1:0]    word;
  mcju_pkg::mcju_kind_e          kind;
  logic [mcju_pkg::ST_SEL_W-1:0] sel;
  logic                          jr;
  logic                          pol;
  logic [mcju_pkg::OFS_W-1:0]    ofs;

  modport dec (input word, output kind, sel, jr, pol, ofs);
  modport use_side (output word, input kind, sel, jr, pol, ofs);
endinterface : mcju_dec_if

`default_nettype wire

// >>> src/mcju_decode.sv
// Purpose: Classifies a word as one of six conditional jumps and splits fields
// Assumes: Word is stable within the cycle
// Notes:   Selector is right aligned; unused high bits read zero
`default_nettype none

module mcju_decode (
  mcju_dec_if.dec d
);

  // ----------------------------------------------------------------
  // Pattern match and field split
  // ----------------------------------------------------------------
  always_comb begin
    d.kind = mcju_pkg::K_NONE;
    d.sel  = '0;
    d.jr   = 1'b0;
    d.pol  = d.word[mcju_pkg::POL_BIT];
    d.ofs  = d.word[mcju_pkg::OFS_W-1:0];
    if (d.word[mcju_pkg::OPC_MSB -: $bits(mcju_pkg::FC_HI)] == mcju_pkg::FC_HI &&
        d.word[$bits(mcju_pkg::FC_LO)-1:0] == mcju_pkg::FC_LO) begin
      d.kind   = mcju_pkg::K_FAR_CORE;
      d.sel[0] = d.word[mcju_pkg::FC_SEL_BIT];
      d.jr     = d.word[mcju_pkg::FC_JR_BIT];
    end else if (d.word[mcju_pkg::OPC_MSB -: $bits(mcju_pkg::RC_HI)] == mcju_pkg::RC_HI) begin
      d.kind   = mcju_pkg::K_REL_CORE;
      d.sel[0] = d.word[mcju_pkg::RC_SEL_BIT];
    end else if (d.word[mcju_pkg::OPC_MSB -: $bits(mcju_pkg::FS_HI)] == mcju_pkg::FS_HI &&
                 d.word[$bits(mcju_pkg::FS_LO)-1:0] == mcju_pkg::FS_LO) begin
      d.kind = mcju_pkg::K_FAR_START;
      d.sel  = d.word[mcju_pkg::SEL_LSB +: mcju_pkg::ST_SEL_W];
      d.jr   = d.word[mcju_pkg::JR_BIT];
    end else if (d.word[mcju_pkg::OPC_MSB -: $bits(mcju_pkg::RS_HI)] == mcju_pkg::RS_HI) begin
      d.kind = mcju_pkg::K_REL_START;
      d.sel  = d.word[mcju_pkg::SEL_LSB +: mcju_pkg::ST_SEL_W];
    end else if (d.word[mcju_pkg::OPC_MSB -: $bits(mcju_pkg::FR_HI)] == mcju_pkg::FR_HI &&
                 d.word[$bits(mcju_pkg::FR_LO)-1:0] == mcju_pkg::FR_LO) begin
      d.kind = mcju_pkg::K_FAR_STAT;
      d.sel  = {1'b0, d.word[mcju_pkg::SEL_LSB +: mcju_pkg::SR_SEL_W]};
      d.jr   = d.word[mcju_pkg::JR_BIT];
    end else if (d.word[mcju_pkg::OPC_MSB -: $bits(mcju_pkg::RR_HI)] == mcju_pkg::RR_HI) begin
      d.kind = mcju_pkg::K_REL_STAT;
      d.sel  = {1'b0, d.word[mcju_pkg::SEL_LSB +: mcju_pkg::SR_SEL_W]};
    end
  end

endmodule : mcju_decode

`default_nettype wire

// >>> src/mcju_top.sv
// Purpose: Resolves conditional jumps on core id, latched starts, status bits
// Assumes: Sequencer presents one instruction per strobe with its own address
// Notes:   Result appears one cycle after the strobe
//
// The plain strobed port was left to the implementer.
`default_nettype none

module mcju_top #(
  parameter int PC_W = mcju_pkg::PC_W
) (
  input  wire logic                         clk_sys,
  input  wire logic                         reset_n,
  input  wire logic [mcju_pkg::RA_W-1:0]    reg_addr,
  input  wire logic [mcju_pkg::RD_W-1:0]    reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [mcju_pkg::RD_W-1:0]    reg_rdata_r,
  input  wire logic                         instr_valid,
  input  wire logic [mcju_pkg::INS_W-1:0]   instr_word,
  input  wire logic [PC_W-1:0]              instr_pc,
  input  wire logic                         core_id,
  input  wire logic [mcju_pkg::ST_N-1:0]    start_latched,
  input  wire logic [PC_W-1:0]              jump_reg1,
  input  wire logic [PC_W-1:0]              jump_reg2,
  output logic                              res_valid_r,
  output logic                              res_taken_r,
  output logic      [PC_W-1:0]              res_target_r,
  output logic                              res_sel_err_r
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PC_W <= mcju_pkg::OFS_W || PC_W > mcju_pkg::LAST_TK_BIT) begin : g_chk
    $error("PC_W must exceed the offset width and fit the last-result word");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [PC_W-1:0] sext(input logic [mcju_pkg::OFS_W-1:0] o);
    return {{(PC_W-mcju_pkg::OFS_W){o[mcju_pkg::OFS_W-1]}}, o};
  endfunction : sext

  function automatic logic [PC_W-1:0] rel_dest(input logic [PC_W-1:0] pc,
                                               input logic [mcju_pkg::OFS_W-1:0] o);
    return PC_W'(pc + sext(o));
  endfunction : rel_dest

  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
    return PC_W'(pc + PC_W'(1));
  endfunction : pc_inc

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  mcju_dec_if dif ();

  assign dif.word = instr_word;

  mcju_decode u_dec (
    .d (dif.dec)
  );

  // ----------------------------------------------------------------
  // Status words
  // ----------------------------------------------------------------
  logic [mcju_pkg::SR_W-1:0] sr0_r;
  logic [mcju_pkg::SR_W-1:0] sr1_r;
  logic [mcju_pkg::SR_W-1:0] sr0_nxt;
  logic [mcju_pkg::SR_W-1:0] sr1_nxt;
  logic                      hit_c0;
  logic                      hit_c1;
  logic                      hit_last;

  always_comb begin
    hit_c0  = reg_addr == mcju_pkg::REG_C0_A || reg_addr == mcju_pkg::REG_C0_B ||
              reg_addr == mcju_pkg::REG_C0_C;
    hit_c1  = reg_addr == mcju_pkg::REG_C1_A || reg_addr == mcju_pkg::REG_C1_B ||
              reg_addr == mcju_pkg::REG_C1_C;
    hit_last = reg_addr == mcju_pkg::REG_LAST;
    sr0_nxt = sr0_r;
    sr1_nxt = sr1_r;
    if (reg_wr && hit_c0) begin
      sr0_nxt = reg_wdata;
    end
    if (reg_wr && hit_c1) begin
      sr1_nxt = reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sr0_r <= mcju_pkg::SR_RST;
      sr1_r <= mcju_pkg::SR_RST;
    end else begin
      sr0_r <= sr0_nxt;
      sr1_r <= sr1_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Condition and target
  // ----------------------------------------------------------------
  logic                      jmp_hit;
  logic                      jmp_far;
  logic                      cond;
  logic                      sel_err;
  logic [mcju_pkg::ST_N-1:0] smask;
  logic [mcju_pkg::SR_W-1:0] own_sr;
  logic [PC_W-1:0]           far_dest;
  logic [PC_W-1:0]           dest;
  logic [PC_W-1:0]           next_pc;

  always_comb begin
    jmp_hit  = instr_valid && dif.kind != mcju_pkg::K_NONE;
    jmp_far  = dif.kind inside {mcju_pkg::K_FAR_CORE, mcju_pkg::K_FAR_START,
                                mcju_pkg::K_FAR_STAT};
    smask    = mcju_pkg::start_mask(dif.sel);
    own_sr   = core_id ? sr1_r : sr0_r;
    far_dest = dif.jr ? jump_reg2 : jump_reg1;
    sel_err  = 1'b0;
    cond     = 1'b0;
    unique case (dif.kind)
      mcju_pkg::K_FAR_CORE, mcju_pkg::K_REL_CORE: begin
        cond = dif.sel[0] == core_id;
      end
      mcju_pkg::K_FAR_START, mcju_pkg::K_REL_START: begin
        if (dif.sel > mcju_pkg::START_MAX) begin
          sel_err = 1'b1;
        end else if (dif.sel == mcju_pkg::START_NONE) begin
          cond = start_latched == '0;
        end else begin
          cond = (start_latched & smask) == smask;
        end
      end
      mcju_pkg::K_FAR_STAT, mcju_pkg::K_REL_STAT: begin
        cond = own_sr[dif.sel[mcju_pkg::SR_SEL_W-1:0]] == dif.pol;
      end
      mcju_pkg::K_NONE: begin
        cond = 1'b0;
      end
    endcase
    dest    = jmp_far ? far_dest : rel_dest(instr_pc, dif.ofs);
    next_pc = cond ? dest : pc_inc(instr_pc);
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  logic                      res_valid_nxt;
  logic                      res_taken_nxt;
  logic [PC_W-1:0]           res_target_nxt;
  logic                      res_sel_err_nxt;
  logic [mcju_pkg::RD_W-1:0] last_r;
  logic [mcju_pkg::RD_W-1:0] last_nxt;

  always_comb begin
    res_valid_nxt   = jmp_hit;
    res_taken_nxt   = jmp_hit && cond;
    res_target_nxt  = jmp_hit ? next_pc : res_target_r;
    res_sel_err_nxt = jmp_hit && sel_err;
    last_nxt        = last_r;
    if (jmp_hit) begin
      last_nxt                        = '0;
      last_nxt[PC_W-1:0]              = next_pc;
      last_nxt[mcju_pkg::LAST_TK_BIT] = cond;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      res_valid_r   <= 1'b0;
      res_taken_r   <= 1'b0;
      res_target_r  <= '0;
      res_sel_err_r <= 1'b0;
      last_r        <= '0;
    end else begin
      res_valid_r   <= res_valid_nxt;
      res_taken_r   <= res_taken_nxt;
      res_target_r  <= res_target_nxt;
      res_sel_err_r <= res_sel_err_nxt;
      last_r        <= last_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [mcju_pkg::RD_W-1:0] reg_rdata_nxt;

  always_comb begin
    reg_rdata_nxt = '0;
    if (reg_rd) begin
      if (hit_c0) begin
        reg_rdata_nxt = sr0_r;
      end else if (hit_c1) begin
        reg_rdata_nxt = sr1_r;
      end else if (hit_last) begin
        reg_rdata_nxt = last_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_r <= '0;
    end else begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_rel_issue;
    instr_valid && dif.kind inside {mcju_pkg::K_REL_CORE, mcju_pkg::K_REL_START,
                                    mcju_pkg::K_REL_STAT};
  endsequence

  sequence s_far_issue;
    instr_valid && jmp_far;
  endsequence

  sequence s_taken;
    res_valid_r && res_taken_r;
  endsequence

  property p_rel_target;
    s_rel_issue ##1 s_taken |->
      res_target_r == PC_W'($past(instr_pc) + sext($past(dif.ofs)));
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("relative target wrong");

  property p_far_target;
    s_far_issue ##1 s_taken |->
      res_target_r == ($past(dif.jr) ? $past(jump_reg2) : $past(jump_reg1));
  endproperty
  a_far_target: assert property (p_far_target) else $error("far target wrong");

  property p_core_cond;
    instr_valid && dif.kind inside {mcju_pkg::K_FAR_CORE, mcju_pkg::K_REL_CORE} |=>
      res_valid_r && res_taken_r == ($past(dif.sel[0]) == $past(core_id));
  endproperty
  a_core_cond: assert property (p_core_cond) else $error("core id condition wrong");

  property p_fall_through;
    res_valid_r && !res_taken_r |-> res_target_r == pc_inc($past(instr_pc));
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("fall through wrong");

  property p_stat_cond;
    instr_valid && dif.kind inside {mcju_pkg::K_FAR_STAT, mcju_pkg::K_REL_STAT} |=>
      res_taken_r == ($past(own_sr[instr_word[mcju_pkg::SEL_LSB +: mcju_pkg::SR_SEL_W]])
                      == $past(instr_word[mcju_pkg::POL_BIT]));
  endproperty
  a_stat_cond: assert property (p_stat_cond) else $error("status condition wrong");

  property p_own_sr;
    instr_valid && dif.kind inside {mcju_pkg::K_FAR_STAT, mcju_pkg::K_REL_STAT} |=>
      res_taken_r == ($past(core_id) ? $past(sr1_r[dif.sel[mcju_pkg::SR_SEL_W-1:0]] == dif.pol)
                                     : $past(sr0_r[dif.sel[mcju_pkg::SR_SEL_W-1:0]] == dif.pol));
  endproperty
  a_own_sr: assert property (p_own_sr) else $error("wrong core status word");

  property p_start_none;
    instr_valid && dif.kind inside {mcju_pkg::K_FAR_START, mcju_pkg::K_REL_START} &&
      dif.sel == mcju_pkg::START_NONE |=> res_taken_r == ($past(start_latched) == '0);
  endproperty
  a_start_none: assert property (p_start_none) else $error("none-latched condition wrong");

  property p_start_bad;
    instr_valid && dif.kind == mcju_pkg::K_REL_START && dif.sel > mcju_pkg::START_MAX |=>
      res_sel_err_r && !res_taken_r ##1 !res_sel_err_r || res_valid_r;
  endproperty
  a_start_bad: assert property (p_start_bad) else $error("illegal start code taken");

  property p_no_hit;
    instr_valid && dif.kind == mcju_pkg::K_NONE |=> !res_valid_r && !res_taken_r;
  endproperty
  a_no_hit: assert property (p_no_hit) else $error("non-jump word resolved");

  property p_sr_read;
    reg_wr && hit_c0 ##1 reg_rd && reg_addr == mcju_pkg::REG_C0_B |=>
      reg_rdata_r == $past(reg_wdata, 2);
  endproperty
  a_sr_read: assert property (p_sr_read) else $error("status word readback wrong");

endmodule : mcju_top

`default_nettype wire

// >>> tb/mcju_seq_model.sv
// Purpose: Program sequencer and code RAM fetch model facing the jump unit
// Assumes: Bench asks for one instruction at a time
// Notes:   Program counter follows every jump result
`default_nettype none

module mcju_seq_model #(
  parameter int PC_W = mcju_pkg::PC_W
) (
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  input  wire logic            go,
  input  wire logic [15:0]     go_word,
  input  wire logic            res_valid,
  input  wire logic [PC_W-1:0] res_target,
  output logic                 instr_valid,
  output logic      [15:0]     instr_word,
  output logic      [PC_W-1:0] instr_pc
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;

  always_comb begin
    pc_nxt = res_valid ? res_target : pc_r;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= '0;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // Fetch path shows junk while no instruction is offered
  assign instr_valid = go;
  assign instr_word  = go ? go_word : ~go_word;
  assign instr_pc    = pc_r;
endmodule : mcju_seq_model

`default_nettype wire

// >>> tb/mcju_bench.sv
// Purpose: Self-checking bench of the conditional jump unit
// Assumes: Jump result one cycle after the instruction strobe
// Notes:   Status words are loaded by the register scenario
`default_nettype none

module mcju_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [9:0]  JR1 = 10'h2A5;
  localparam logic [9:0]  JR2 = 10'h15A;
  localparam logic [15:0] W0  = 16'hA5C3;
  localparam logic [15:0] W1  = 16'h5A3C;
  localparam logic [7:0]  HI_MASK [12] = '{8'h10, 8'h40, 8'h50, 8'h60, 8'h80, 8'h90,
                                           8'hA0, 8'hB0, 8'hC0, 8'hD0, 8'hE0, 8'hF0};

  logic        clk_sys;
  logic        reset_n;
  logic [8:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata_r;
  logic        instr_valid;
  logic [15:0] instr_word;
  logic [9:0]  instr_pc;
  logic        core_id;
  logic [7:0]  start_latched;
  logic        res_valid_r;
  logic        res_taken_r;
  logic [9:0]  res_target_r;
  logic        res_sel_err_r;
  logic        go;
  logic [15:0] go_word;
  logic [9:0]  pc;
  logic [9:0]  jr1;
  logic [9:0]  jr2;
  int          miscompares;
  int          comparisons;

  mcju_top DUT (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata_r   (reg_rdata_r),
    .instr_valid   (instr_valid),
    .instr_word    (instr_word),
    .instr_pc      (instr_pc),
    .core_id       (core_id),
    .start_latched (start_latched),
    .jump_reg1     (jr1),
    .jump_reg2     (jr2),
    .res_valid_r   (res_valid_r),
    .res_taken_r   (res_taken_r),
    .res_target_r  (res_target_r),
    .res_sel_err_r (res_sel_err_r)
  );

  mcju_seq_model u_seq (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .go          (go),
    .go_word     (go_word),
    .res_valid   (res_valid_r),
    .res_target  (res_target_r),
    .instr_valid (instr_valid),
    .instr_word  (instr_word),
    .instr_pc    (instr_pc)
  );

  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata_r, exp);
  endtask : rd

  // Write followed at once by a read of an alias of the same word
  task automatic wrrd(input logic [8:0] a, input logic [15:0] d, input logic [8:0] b);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= b;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata_r, d);
  endtask : wrrd

  function automatic logic [9:0] rel(input logic [4:0] o);
    return pc + {{5{o[4]}}, o};
  endfunction : rel

  // One word; a held condition goes to tgt, otherwise to the next address
  task automatic jump(input logic [15:0] w, input logic c, input logic [7:0] st, input logic v,
                      input logic tk, input logic [9:0] tgt, input logic er);
    logic [9:0] nxt;
    nxt = tk ? tgt : pc + 10'h001;
    @(posedge clk_sys);
    go            <= 1'b1;
    go_word       <= w;
    core_id       <= c;
    start_latched <= st;
    @(posedge clk_sys);
    go <= 1'b0;
    #1;
    check(res_valid_r, v);
    check(res_taken_r, tk & v);
    check(res_sel_err_r, er);
    if (v) begin
      check(res_target_r, nxt);
      pc = nxt;
    end
  endtask : jump

  task automatic t_regs();
    #1 check(res_valid_r, 1'b0);
    rd(9'h105, 16'h0000);
    rd(9'h146, 16'h0000);
    wrrd(9'h105, W0, 9'h125);
    wr(9'h126, W1);
    rd(9'h145, W0);
    rd(9'h106, W1);
    rd(9'h0FF, 16'h0000);
    wr(9'h160, 16'hFFFF);
    rd(9'h160, 16'h0000);
  endtask : t_regs

  task automatic t_core();
    logic [4:0] o;
    for (int k = 0; k < 8; k++) begin
      o = k[0] ? 5'h0F : 5'h10;
      jump({10'h0BD, k[1], o}, k[2], 8'h00, 1'b1, k[1] == k[2], rel(o), 1'b0);
      jump({11'h1CC, k[1], k[0], 3'h5}, k[2], 8'h00, 1'b1, k[1] == k[2], k[0] ? JR2 : JR1, 1'b0);
    end
  endtask : t_core

  task automatic t_start();
    logic [4:0] c;
    logic [7:0] m;
    logic [7:0] st;
    logic       ok;
    for (int k = 0; k < 128; k++) begin
      c  = k[6:2];
      ok = k[1];
      m  = !c[4] ? {4'h0, c[3:0]} : (c[3:0] < 4'hC ? HI_MASK[c[3:0]] : 8'h00);
      st = (c == 5'h00) ? {7'h00, !ok} : (ok ? m : m & (m - 8'h01));
      if (k[0]) begin
        jump({6'h05, c, 5'h0B}, 1'b0, st, 1'b1, ok && c < 5'h1C, rel(5'h0B), c > 5'h1B);
      end else begin
        jump({6'h0E, c, ok, 4'h4}, 1'b1, st, 1'b1, ok && c < 5'h1C, ok ? JR2 : JR1, c > 5'h1B);
      end
    end
  endtask : t_start

  task automatic t_stat();
    logic [3:0]  b;
    logic        p;
    logic        c;
    logic [15:0] w;
    for (int k = 0; k < 128; k++) begin
      {c, b, p} = k[5:0];
      w = c ? W1 : W0;
      if (k[6]) begin
        jump({6'h0C, p, b, p, b}, c, 8'h00, 1'b1, w[b] == p, rel({p, b}), 1'b0);
      end else begin
        jump({6'h0F, p, b, b[0], 4'h5}, c, 8'h00, 1'b1, w[b] == p, b[0] ? JR2 : JR1, 1'b0);
      end
    end
  endtask : t_stat

  task automatic t_other();
    jump(16'h3995, 1'b1, 8'h00, 1'b1, 1'b1, JR1, 1'b0);
    rd(9'h160, {6'h20, JR1});
    jump(16'h0000, 1'b0, 8'h00, 1'b0, 1'b0, 10'h000, 1'b0);
    jump(16'h39BD, 1'b0, 8'h00, 1'b0, 1'b0, 10'h000, 1'b0);
    @(posedge clk_sys);
    jr2 <= 10'h3FF;
    jump({11'h1CC, 1'b0, 1'b1, 3'h5}, 1'b0, 8'h00, 1'b1, 1'b1, 10'h3FF, 1'b0);
    rd(9'h160, {6'h20, 10'h3FF});
  endtask : t_other

  initial begin
    reset_n       = 1'b0;
    reg_addr      = 9'h000;
    reg_wdata     = 16'h0000;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    core_id       = 1'b0;
    start_latched = 8'h00;
    go            = 1'b0;
    go_word       = 16'h0000;
    pc            = 10'h000;
    jr1           = JR1;
    jr2           = JR2;
    miscompares   = 0;
    comparisons   = 0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_core();
    t_start();
    t_stat();
    t_other();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    test_done();
  end
endmodule : mcju_bench

`default_nettype wire
